// [rtl/pdt_defs.vh]
// constants for the payload discrete and telemetry block
// assumes a 100 MHz system clock; times are in ms or us as named
`ifndef PDT_DEFS_VH
`define PDT_DEFS_VH
`define PDT_CLK_MHZ        100
`define PDT_TICK_US        1000
`define PDT_TICK_CYC       (`PDT_CLK_MHZ * `PDT_TICK_US)
`define PDT_FIRE_MS        40
`define PDT_SKEW_NEAR_MS   0
`define PDT_SKEW_FAR_MS    80
`define PDT_CMD_MIN_MS     20
`define PDT_CMD_MAX_MS     10000
`define PDT_CMD_TOTAL_MS   50000
`define PDT_CMD_CHANGES    10
`define PDT_CMD_N          16
`define PDT_FIRE_N         8
`endif

// [rtl/pdt_payload_io.v]
// in-flight payload functions: firing pairs, command outputs, separation, telemetry
// assumes commands come from same-clock flight logic; pins are async
`timescale 1ns/1ns
`include "pdt_defs.vh"
module pdt_payload_io #(
   parameter TICK_CYC = `PDT_TICK_CYC,
   parameter W        = 8
) (
   input  wire                   clock,
   input  wire                   rst,
   input  wire                   skew_far,
   input  wire [`PDT_FIRE_N-1:0] fire_cmd,
   output reg  [`PDT_FIRE_N-1:0] fire_pri,
   output reg  [`PDT_FIRE_N-1:0] fire_bak,
   output wire [`PDT_FIRE_N-1:0] safe_pri,
   output wire [`PDT_FIRE_N-1:0] safe_bak,
   input  wire                   closure_mode,
   input  wire [`PDT_CMD_N-1:0]  cmd_req,
   output reg  [`PDT_CMD_N-1:0]  cmd_on,
   output wire [`PDT_CMD_N-1:0]  disc_drive,
   output wire [`PDT_CMD_N-1:0]  relay_close,
   output reg  [`PDT_CMD_N-1:0]  cmd_refused,
   input  wire [1:0]             sep_loop,
   output reg                    sep_flag,
   input  wire                   tm_sel,
   input  wire [1:0]             tm_clk,
   input  wire [1:0]             tm_data,
   output reg  [W-1:0]           tm_word,
   output reg                    tm_valid
);
   localparam FIRE_T  = `PDT_FIRE_MS;
   localparam FAR_T   = `PDT_SKEW_FAR_MS;
   localparam MIN_T   = `PDT_CMD_MIN_MS;
   localparam MAX_T   = `PDT_CMD_MAX_MS;
   localparam TOTAL_T = `PDT_CMD_TOTAL_MS;

   ////////////////////////////////////////////////////////////////////
   // ms tick divider
   reg [31:0] div_reg;
   reg        tick_reg;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         div_reg  <= 32'h0;
         tick_reg <= 1'h0;
      end else if (div_reg == TICK_CYC - 1) begin
         div_reg  <= 32'h0;
         tick_reg <= 1'h1;
      end else begin
         div_reg  <= div_reg + 32'h1;
         tick_reg <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // firing pairs, each independent
   reg                  mode_reg;
   reg [7:0]            fp_cnt  [0:`PDT_FIRE_N-1];
   reg [7:0]            fb_cnt  [0:`PDT_FIRE_N-1];
   reg [`PDT_FIRE_N-1:0] used_reg;
   // skew mode latched after reset so it cannot change mid-flight
   reg                  mode_set_reg;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_reg     <= 1'h0;
         mode_set_reg <= 1'h0;
      end else if (!mode_set_reg) begin
         mode_reg     <= skew_far;
         mode_set_reg <= 1'h1;
      end
   end

   assign safe_pri = ~fire_pri;
   assign safe_bak = ~fire_bak;

   genvar i;
   generate
      for (i = 0; i < `PDT_FIRE_N; i = i + 1) begin : g_fire
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               fp_cnt[i]   <= 8'h0;
               fb_cnt[i]   <= 8'h0;
               used_reg[i] <= 1'h0;
               fire_pri[i] <= 1'h0;
               fire_bak[i] <= 1'h0;
            end else begin
               if (fire_cmd[i] && !used_reg[i]) begin
                  used_reg[i] <= 1'h1;
                  fire_pri[i] <= 1'h1;
                  fp_cnt[i]   <= 8'h0;
                  fb_cnt[i]   <= 8'h0;
                  fire_bak[i] <= !mode_reg;
               end else if (used_reg[i] && tick_reg) begin
                  if (fire_pri[i]) begin
                     if (fp_cnt[i] == FIRE_T - 1)
                        fire_pri[i] <= 1'h0;
                     fp_cnt[i] <= fp_cnt[i] + 8'h1;
                  end
                  if (fb_cnt[i] != 8'hff)
                     fb_cnt[i] <= fb_cnt[i] + 8'h1;
                  if (mode_reg && fb_cnt[i] == FAR_T - 1)
                     fire_bak[i] <= 1'h1;
                  else if (fire_bak[i] && fb_cnt[i] ==
                           (mode_reg ? FAR_T + FIRE_T - 1 : FIRE_T - 1))
                     fire_bak[i] <= 1'h0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // command outputs
   reg        closure_reg;
   reg        cfg_set_reg;
   reg [13:0] iv_cnt  [0:`PDT_CMD_N-1];
   reg [15:0] tot_cnt [0:`PDT_CMD_N-1];
   reg [3:0]  chg_cnt [0:`PDT_CMD_N-1];

   // one configuration for all sixteen, fixed after reset
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         closure_reg <= 1'h0;
         cfg_set_reg <= 1'h0;
      end else if (!cfg_set_reg) begin
         closure_reg <= closure_mode;
         cfg_set_reg <= 1'h1;
      end
   end
   assign disc_drive  = closure_reg ? {`PDT_CMD_N{1'b0}} : cmd_on;
   assign relay_close = closure_reg ? cmd_on : {`PDT_CMD_N{1'b0}};

   generate
      for (i = 0; i < `PDT_CMD_N; i = i + 1) begin : g_cmd
         wire want_change = (cmd_req[i] != cmd_on[i]);
         wire min_ok      = (iv_cnt[i] >= MIN_T);
         wire chg_ok      = (chg_cnt[i] < `PDT_CMD_CHANGES);
         // a turn-on needs room for a full minimum interval in the budget
         wire accept      = want_change && min_ok && chg_ok &&
                            !(cmd_req[i] && tot_cnt[i] >= TOTAL_T - MIN_T);
         // forced off if interval or total on-time runs out; costs a change
         wire force_off   = cmd_on[i] && ((iv_cnt[i] >= MAX_T) ||
                                          (tot_cnt[i] >= TOTAL_T));
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               cmd_on[i]      <= 1'h0;
               iv_cnt[i]      <= 14'h0;
               tot_cnt[i]     <= 16'h0;
               chg_cnt[i]     <= 4'h0;
               cmd_refused[i] <= 1'h0;
            end else begin
               cmd_refused[i] <= want_change && !accept && !force_off;
               if (force_off) begin
                  cmd_on[i]  <= 1'h0;
                  iv_cnt[i]  <= 14'h0;
                  chg_cnt[i] <= chg_cnt[i] + 4'h1;
               end else if (accept) begin
                  cmd_on[i]  <= cmd_req[i];
                  iv_cnt[i]  <= 14'h0;
                  chg_cnt[i] <= chg_cnt[i] + 4'h1;
               end else if (tick_reg) begin
                  if (iv_cnt[i] != 14'h3fff)
                     iv_cnt[i] <= iv_cnt[i] + 14'h1;
                  if (cmd_on[i])
                     tot_cnt[i] <= tot_cnt[i] + 16'h1;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // separation loops, synchronised; either loop open flags separation
   reg [1:0] sep_s1_reg;
   reg [1:0] sep_s2_reg;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sep_s1_reg <= 2'h3;
         sep_s2_reg <= 2'h3;
         sep_flag   <= 1'h0;
      end else begin
         sep_s1_reg <= sep_loop;
         sep_s2_reg <= sep_s1_reg;
         if (sep_s2_reg != 2'h3)
            sep_flag <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // telemetry: two channels, only the selected one accepts
   reg          sel_s1_reg;
   reg          sel_reg;
   wire [W-1:0] w0;
   wire [W-1:0] w1;
   wire         v0;
   wire         v1;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_s1_reg <= 1'h0;
         sel_reg    <= 1'h0;
         tm_word    <= {W{1'b0}};
         tm_valid   <= 1'h0;
      end else begin
         sel_s1_reg <= tm_sel;
         sel_reg    <= sel_s1_reg;
         tm_valid   <= sel_reg ? v1 : v0;
         if (sel_reg ? v1 : v0)
            tm_word <= sel_reg ? w1 : w0;
      end
   end

   // rate limit is the payload's side; 2 kBps is far below sampling
   pdt_rx_chan #(.W(W)) u_rx0 (
      .clock      (clock),
      .rst        (rst),
      .enable     (!sel_reg),
      .tm_clk     (tm_clk[0]),
      .tm_data    (tm_data[0]),
      .word       (w0),
      .word_valid (v0)
   );
   pdt_rx_chan #(.W(W)) u_rx1 (
      .clock      (clock),
      .rst        (rst),
      .enable     (sel_reg),
      .tm_clk     (tm_clk[1]),
      .tm_data    (tm_data[1]),
      .word       (w1),
      .word_valid (v1)
   );
endmodule // pdt_payload_io

// [rtl/pdt_rx_chan.v]
// one telemetry receive channel: syncs clock/data, shifts on rising clock
// assumes link clock far slower than the system clock
`timescale 1ns/1ns
module pdt_rx_chan #(
   parameter W = 8
) (
   input  wire         clock,
   input  wire         rst,
   input  wire         enable,
   input  wire         tm_clk,
   input  wire         tm_data,
   output reg  [W-1:0] word,
   output reg          word_valid
);
   reg [1:0]          clk_sync_reg;
   reg [1:0]          dat_sync_reg;
   reg                clk_prev_reg;
   reg [W-1:0]        shift_reg;
   reg [3:0]          count_reg;
   wire               rise;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_sync_reg <= 2'h0;
         dat_sync_reg <= 2'h0;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], tm_clk};
         dat_sync_reg <= {dat_sync_reg[0], tm_data};
      end
   end

   // edge seen only on the second stage
   assign rise = clk_sync_reg[1] & ~clk_prev_reg;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_prev_reg <= 1'h0;
         shift_reg    <= {W{1'b0}};
         count_reg    <= 4'h0;
         word         <= {W{1'b0}};
         word_valid   <= 1'h0;
      end else begin
         clk_prev_reg <= clk_sync_reg[1];
         word_valid   <= 1'h0;
         if (!enable) begin
            count_reg <= 4'h0;
         end else if (rise) begin
            shift_reg <= {shift_reg[W-2:0], dat_sync_reg[1]};
            if (count_reg == W - 1) begin
               count_reg  <= 4'h0;
               word       <= {shift_reg[W-2:0], dat_sync_reg[1]};
               word_valid <= 1'h1;
            end else begin
               count_reg <= count_reg + 4'h1;
            end
         end
      end
   end
endmodule // pdt_rx_chan

// [test/pdt_payload_io_checker.sv]
// checker for pdt_payload_io, bound to its ports
// assumes skew_far and closure_mode change only while rst is high
`timescale 1ns/1ns
`include "pdt_defs.vh"
module pdt_payload_io_checker (
   input wire                   clock,
   input wire                   rst,
   input wire                   skew_far,
   input wire [`PDT_FIRE_N-1:0] fire_cmd,
   input wire [`PDT_FIRE_N-1:0] fire_pri,
   input wire [`PDT_FIRE_N-1:0] fire_bak,
   input wire [`PDT_FIRE_N-1:0] safe_pri,
   input wire [`PDT_FIRE_N-1:0] safe_bak,
   input wire                   closure_mode,
   input wire [`PDT_CMD_N-1:0]  cmd_req,
   input wire [`PDT_CMD_N-1:0]  cmd_on,
   input wire [`PDT_CMD_N-1:0]  disc_drive,
   input wire [`PDT_CMD_N-1:0]  relay_close,
   input wire [1:0]             sep_loop,
   input wire                   sep_flag,
   input wire                   tm_valid
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence loop_open4;
      (sep_loop != 2'h3) [*4];
   endsequence
   ////////////////////////////////////////////////////////////
   safe_pri_a: assert property (safe_pri == ~fire_pri) else $error("pri not shorted");
   safe_bak_a: assert property (safe_bak == ~fire_bak) else $error("bak not shorted");
   fire_cause_a: assert property ((fire_pri & ~$past(fire_pri) & ~$past(fire_cmd)) == 8'h00)
      else $error("fire without request");
   near_pair_a: assert property (!skew_far |-> fire_bak == fire_pri)
      else $error("near backup apart");
   far_lag_a: assert property (skew_far |-> (fire_bak & fire_pri & ~$past(fire_pri)) == 8'h00)
      else $error("far backup too early");
   mode_excl_a: assert property ((disc_drive & relay_close) == 16'h0000)
      else $error("mixed outputs");
   relay_map_a: assert property (relay_close == (closure_mode ? cmd_on : 16'h0000))
      else $error("relay state wrong");
   cmd_cause_a: assert property ((cmd_on & ~$past(cmd_on) & ~$past(cmd_req)) == 16'h0000)
      else $error("unrequested turn-on");
   sep_hold_a: assert property (sep_flag |=> sep_flag) else $error("sep flag dropped");
   sep_set_a: assert property (loop_open4 |-> sep_flag) else $error("sep not flagged");
   tm_pulse_a: assert property (tm_valid |=> !tm_valid) else $error("valid too long");
endmodule // pdt_payload_io_checker
bind pdt_payload_io pdt_payload_io_checker pdt_payload_io_checker_inst (.clock, .rst,
   .skew_far, .fire_cmd, .fire_pri, .fire_bak, .safe_pri, .safe_bak, .closure_mode, .cmd_req,
   .cmd_on, .disc_drive, .relay_close, .sep_loop, .sep_flag, .tm_valid);

// [test/pdt_payload_io_tb.sv]
// bench for pdt_payload_io: firing pairs, commands, separation, telemetry
// assumes pdt_tm_source drives the telemetry pins; tick shortened to 10 cycles
`timescale 1ns/1ns
module pdt_payload_io_tb;
   logic        clock = 0, rst = 1, skew_far = 0, closure_mode = 0, tm_sel = 0;
   logic [7:0]  fire_cmd = 8'h00;
   logic [15:0] cmd_req = 16'h0000;
   logic [1:0]  sep_loop = 2'h3;
   wire  [1:0]  tm_clk, tm_data;
   wire  [7:0]  fire_pri, fire_bak, safe_pri, safe_bak, tm_word;
   wire  [15:0] cmd_on, disc_drive, relay_close, cmd_refused;
   wire         sep_flag, tm_valid;
   int          fail_count = 0, checks = 0, cyc = 0, n;
   pdt_payload_io #(.TICK_CYC(10)) pdt_payload_io_inst (.clock, .rst, .skew_far, .fire_cmd,
      .fire_pri, .fire_bak, .safe_pri, .safe_bak, .closure_mode, .cmd_req, .cmd_on,
      .disc_drive, .relay_close, .cmd_refused, .sep_loop, .sep_flag, .tm_sel, .tm_clk,
      .tm_data, .tm_word, .tm_valid);
   pdt_tm_source pdt_tm_source_inst (.tm_clk, .tm_data);
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 12000) begin
         fail_count++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic far, input logic cl);
      @(negedge clock);
      rst = 1;
      skew_far = far;
      closure_mode = cl;
      repeat (2) @(negedge clock);
      rst = 0;
      repeat (2) @(negedge clock);
   endtask
   task automatic wait_pri(input logic [7:0] v);
      n = 0;
      while (fire_pri !== v && n < 4) begin
         @(negedge clock);
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_fire;
      fire_cmd = 8'h09;   // two pairs at once
      wait_pri(8'h09);
      chk(fire_pri, 8'h09);
      chk(fire_bak, 8'h09);
      chk(safe_pri, 8'hf6);
      n = 0;
      while (fire_pri[0] === 1'b1 && n < 500) begin
         @(negedge clock);
         n++;
      end
      chk(n >= 380 && n <= 401, 1);
      fire_cmd = 8'h00;
      @(negedge clock);
      fire_cmd = 8'h01;   // second request on a spent pair
      repeat (20) @(negedge clock);
      chk(fire_pri, 8'h00);
      chk(fire_bak, 8'h00);
      fire_cmd = 8'h00;
      $display("t_fire done");
   endtask
   task automatic t_far;
      fire_cmd = 8'h20;
      wait_pri(8'h20);
      n = 0;
      while (fire_bak[5] !== 1'b1 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      chk(n >= 785 && n <= 801, 1);
      chk(fire_pri[5], 0);
      n = 0;
      while (fire_bak[5] === 1'b1 && n < 500) begin
         @(negedge clock);
         n++;
      end
      chk(n >= 380 && n <= 401, 1);
      fire_cmd = 8'h00;
      $display("t_far done");
   endtask
   task automatic t_cmd(input logic cl);
      repeat (210) @(negedge clock);
      cmd_req = 16'h0004;
      repeat (2) @(negedge clock);
      chk(cmd_on, 16'h0004);
      chk(relay_close, cl ? 16'h0004 : 16'h0000);
      chk(disc_drive, cl ? 16'h0000 : 16'h0004);
      repeat (50) @(negedge clock);
      cmd_req = 16'h0000;   // too soon: interval still short
      repeat (3) @(negedge clock);
      chk(cmd_refused[2], 1);
      n = 0;
      while (cmd_on[2] !== 1'b0 && n < 300) begin
         @(negedge clock);
         n++;
      end
      chk(n >= 130 && n <= 155, 1);
      $display("t_cmd done");
   endtask
   task automatic t_chg;
      for (int k = 0; k < 10; k++) begin
         repeat (210) @(negedge clock);
         cmd_req[5] = ~cmd_req[5];
         repeat (2) @(negedge clock);
         chk(cmd_on[5], cmd_req[5]);
      end
      repeat (210) @(negedge clock);
      cmd_req[5] = 1'b1;   // eleventh change must be refused
      repeat (3) @(negedge clock);
      chk(cmd_on[5], 0);
      chk(cmd_refused[5], 1);
      cmd_req[5] = 1'b0;
      $display("t_chg done");
   endtask
   task automatic t_sep;
      chk(sep_flag, 0);
      sep_loop = 2'h2;
      repeat (5) @(negedge clock);
      sep_loop = 2'h3;
      repeat (3) @(negedge clock);
      chk(sep_flag, 1);
      $display("t_sep done");
   endtask
   task automatic rx(input int ch, input logic [7:0] b, input logic ok);
      logic seen;
      seen = 0;
      fork
         pdt_tm_source_inst.send(ch, b);
         for (int i = 0; i < 120; i++) begin
            @(negedge clock);
            if (tm_valid === 1'b1 && !seen) begin
               seen = 1;
               chk(tm_word, b);
            end
         end
      join
      chk(seen, ok);
   endtask
   task automatic t_tm;
      rx(0, 8'ha5, 1);
      rx(1, 8'h3c, 0);
      tm_sel = 1;
      repeat (4) @(negedge clock);
      rx(1, 8'h3c, 1);
      rx(0, 8'h81, 0);
      $display("t_tm done");
   endtask
   initial begin
      do_reset(0, 0);
      t_fire();
      t_cmd(0);
      t_sep();
      t_tm();
      do_reset(1, 1);
      t_far();
      t_cmd(1);
      t_chg();
      wrap_up();
   end
endmodule // pdt_payload_io_tb

// [test/pdt_tm_source.sv]
// partner model: payload telemetry source, clock and data per channel
// assumes the bench calls send from one process at a time
`timescale 1ns/1ns
module pdt_tm_source (
   output logic [1:0] tm_clk,
   output logic [1:0] tm_data
);
   initial begin
      tm_clk  = 2'h0;
      tm_data = 2'h0;
   end
   // link clock stands low outside frames; nrz data, msb first
   task automatic send(input int ch, input logic [7:0] b);
      #3;
      for (int i = 7; i >= 0; i--) begin
         tm_data[ch] = b[i];   // change only while clock low
         #40 tm_clk[ch] = 1'b1;
         #40 tm_clk[ch] = 1'b0;
      end
      #20 tm_data[ch] = ~b[0];   // released line must not keep last bit
   endtask
endmodule // pdt_tm_source
